/* File: cos_irq_pkg.sv */
// Package: register map, field layouts, reset values and bus types for the
// change-of-state / level interrupt block.
// Assumes a 32-bit AXI4-Lite register bus and eight monitored channels.
package cos_irq_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int unsigned NUM_CH     = 8;
    localparam int unsigned ADDR_W     = 16;
    localparam int unsigned DATA_W     = 32;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_INT_ENABLE   = 16'h8014;
    localparam logic [ADDR_W-1:0] OFS_TRIGGER_TYPE = 16'h8018;
    localparam logic [ADDR_W-1:0] OFS_LEVEL_POL    = 16'h801c;
    localparam logic [ADDR_W-1:0] OFS_INT_STATUS   = 16'h8020;
    localparam logic [ADDR_W-1:0] OFS_INT_MASK     = 16'h8024;
    localparam logic [ADDR_W-1:0] OFS_INPUT_DATA   = 16'h8028;

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int unsigned      CH_LSB        = 0;
    localparam logic [7:0]       RST_ENABLE    = 8'h00;
    localparam logic [7:0]       RST_TYPE      = 8'h00;
    localparam logic [7:0]       RST_POL       = 8'h00;
    localparam logic [7:0]       RST_STATUS    = 8'h00;
    localparam logic [7:0]       RST_MASK      = 8'hff;

    // AXI4-Lite responses
    localparam logic [1:0]       RESP_OKAY     = 2'h0;
    localparam logic [1:0]       RESP_SLVERR   = 2'h2;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] awaddr;
        logic              awvalid;
        logic [DATA_W-1:0] wdata;
        logic [3:0]        wstrb;
        logic              wvalid;
        logic              bready;
        logic [ADDR_W-1:0] araddr;
        logic              arvalid;
        logic              rready;
    } axil_req_t;

    typedef struct packed {
        logic              awready;
        logic              wready;
        logic [1:0]        bresp;
        logic              bvalid;
        logic              arready;
        logic [DATA_W-1:0] rdata;
        logic [1:0]        rresp;
        logic              rvalid;
    } axil_rsp_t;

endpackage : cos_irq_pkg

/* File: cos_irq_ctrl.sv */
// Interrupt controller for eight monitored input channels.
// Assumes asynchronous channel inputs (synchronised here) and an AXI4-Lite master.
// Usage notes
// Set type and polarity before enable, or a stale level match latches at once.
// A level-mode bit re-latches while its condition holds: clear it only after the
// input has moved or the channel is disabled.
// A zero mask bit hides a pending bit from o_irq without clearing it.
// Pulses shorter than two clock periods may be missed by the synchroniser.
// Only byte lane 0 holds channel bits; writes without it change nothing.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps

// ------------------------------------------------------------
// Pin synchroniser
// ------------------------------------------------------------
// Three stages; the settled level moves only once stages 2 and 3 agree,
// so one metastable sample in stage 1 never reaches the detector.
module cos_irq_pin_sync (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // Pin, asynchronous to i_clk
    input  wire logic i_pin,
    // Settled level, registered and next
    output logic      o_level,
    output logic      o_level_nxt
);

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic sync3;
        logic level;
    } pin_sync_t;

    pin_sync_t state_ff;
    pin_sync_t nxt_state;

    always_comb begin
        nxt_state       = state_ff;
        nxt_state.sync1 = i_pin;
        nxt_state.sync2 = state_ff.sync1;
        nxt_state.sync3 = state_ff.sync2;
        if (state_ff.sync2 == state_ff.sync3) begin
            nxt_state.level = state_ff.sync3;
        end
    end

    // Level resets low; enables are low too, so a pin idling high cannot
    // raise a stray edge before software arms its channel
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign o_level     = state_ff.level;
    assign o_level_nxt = nxt_state.level;

endmodule : cos_irq_pin_sync

// ------------------------------------------------------------
// Channel trigger decision
// ------------------------------------------------------------
// Purely combinational; kept per channel so the gating reads the same
// for every bit, while the pending bit stays next to the clear logic.
module cos_irq_chan_detect (
    // Configuration
    input  wire logic i_enable,
    input  wire logic i_change_mode,
    input  wire logic i_polarity,
    // Settled level, now and next
    input  wire logic i_level,
    input  wire logic i_level_nxt,
    // Decision
    output logic      o_event
);

    logic level_hit;
    logic edge_hit;

    always_comb begin
        // Polarity only matters in level mode
        level_hit = (i_level == i_polarity);
        edge_hit  = (i_level_nxt != i_level);
        if (!i_enable) begin
            o_event = 1'b0;
        end else if (i_change_mode) begin
            o_event = edge_hit;
        end else begin
            o_event = level_hit;
        end
    end

endmodule : cos_irq_chan_detect

module cos_irq_ctrl
    import cos_irq_pkg::*;
(
    // Clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    // Register bus
    input  wire axil_req_t         i_axil,
    output axil_rsp_t              o_axil,
    // Monitored channels (8..15)
    input  wire logic [NUM_CH-1:0] i_chan,
    // Interrupt
    output logic                   o_irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [NUM_CH-1:0] enable;
        logic [NUM_CH-1:0] change_of_state_mode;
        logic [NUM_CH-1:0] polarity;
        logic [NUM_CH-1:0] status;
        logic [NUM_CH-1:0] mask;
        logic              aw_held;
        logic [ADDR_W-1:0] aw_addr;
        logic              w_held;
        logic [DATA_W-1:0] w_data;
        logic [3:0]        w_strb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0]        rresp;
    } state_t;

    state_t state_ff;
    state_t nxt_state;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        logic hit;
        hit = 1'b0;
        if (a == OFS_INT_ENABLE) begin
            hit = 1'b1;
        end else if (a == OFS_TRIGGER_TYPE) begin
            hit = 1'b1;
        end else if (a == OFS_LEVEL_POL) begin
            hit = 1'b1;
        end else if (a == OFS_INT_STATUS) begin
            hit = 1'b1;
        end else if (a == OFS_INT_MASK) begin
            hit = 1'b1;
        end else if (a == OFS_INPUT_DATA) begin
            hit = 1'b1;
        end
        return hit;
    endfunction : mapped

    // Only byte lane 0 carries channel bits; upper lanes are don't-care
    function automatic logic [NUM_CH-1:0] merge(input logic [NUM_CH-1:0] old,
                                                input logic [DATA_W-1:0] d,
                                                input logic [3:0]        s);
        logic [NUM_CH-1:0] r;
        r = s[0] ? d[CH_LSB +: NUM_CH] : old;
        return r;
    endfunction : merge

    function automatic logic [1:0] resp_for(input logic [ADDR_W-1:0] a);
        return mapped(a) ? RESP_OKAY : RESP_SLVERR;
    endfunction : resp_for

    // ------------------------------------------------------------
    // Channels, bit i is channel 8+i
    // ------------------------------------------------------------
    logic [NUM_CH-1:0] chan_level;
    logic [NUM_CH-1:0] chan_level_nxt;
    logic [NUM_CH-1:0] event_hit;

    for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
        cos_irq_pin_sync cos_irq_pin_sync_i (
            .i_clk       (i_clk),
            .i_rst       (i_rst),
            .i_pin       (i_chan[g]),
            .o_level     (chan_level[g]),
            .o_level_nxt (chan_level_nxt[g])
        );
        cos_irq_chan_detect cos_irq_chan_detect_i (
            .i_enable      (state_ff.enable[g]),
            .i_change_mode (state_ff.change_of_state_mode[g]),
            .i_polarity    (state_ff.polarity[g]),
            .i_level       (chan_level[g]),
            .i_level_nxt   (chan_level_nxt[g]),
            .o_event       (event_hit[g])
        );
    end

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    logic              do_write;
    logic [ADDR_W-1:0] waddr;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              do_read;
    logic [ADDR_W-1:0] raddr;
    logic [NUM_CH-1:0] clr;
    logic [NUM_CH-1:0] rd_bits;
    logic              sel_enable;
    logic              sel_type;
    logic              sel_pol;
    logic              sel_status;
    logic              sel_mask;

    // Lane bits of the address are dropped, so every byte of a word hits it
    assign waddr = {state_ff.aw_addr[ADDR_W-1:2], 2'h0};
    assign wdata = state_ff.w_data;
    assign wstrb = state_ff.w_strb;
    assign raddr = {i_axil.araddr[ADDR_W-1:2], 2'h0};

    // Write target
    always_comb begin
        sel_enable = 1'b0;
        sel_type   = 1'b0;
        sel_pol    = 1'b0;
        sel_status = 1'b0;
        sel_mask   = 1'b0;
        if (waddr == OFS_INT_ENABLE) begin
            sel_enable = 1'b1;
        end else if (waddr == OFS_TRIGGER_TYPE) begin
            sel_type = 1'b1;
        end else if (waddr == OFS_LEVEL_POL) begin
            sel_pol = 1'b1;
        end else if (waddr == OFS_INT_STATUS) begin
            sel_status = 1'b1;
        end else if (waddr == OFS_INT_MASK) begin
            sel_mask = 1'b1;
        end
    end

    // Read source; unmapped words read zero
    always_comb begin
        rd_bits = '0;
        if (raddr == OFS_INT_ENABLE) begin
            rd_bits = state_ff.enable;
        end else if (raddr == OFS_TRIGGER_TYPE) begin
            rd_bits = state_ff.change_of_state_mode;
        end else if (raddr == OFS_LEVEL_POL) begin
            rd_bits = state_ff.polarity;
        end else if (raddr == OFS_INT_STATUS) begin
            rd_bits = state_ff.status;
        end else if (raddr == OFS_INT_MASK) begin
            rd_bits = state_ff.mask;
        end else if (raddr == OFS_INPUT_DATA) begin
            rd_bits = chan_level;
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;

        // AXI write: address and data taken in either order
        if (i_axil.awvalid && !state_ff.aw_held) begin
            nxt_state.aw_held = 1'b1;
            nxt_state.aw_addr = i_axil.awaddr;
        end
        if (i_axil.wvalid && !state_ff.w_held) begin
            nxt_state.w_held = 1'b1;
            nxt_state.w_data = i_axil.wdata;
            nxt_state.w_strb = i_axil.wstrb;
        end
        do_write = state_ff.aw_held && state_ff.w_held && !state_ff.bvalid;
        clr      = '0;
        if (do_write) begin
            nxt_state.aw_held = 1'b0;
            nxt_state.w_held  = 1'b0;
            nxt_state.bvalid  = 1'b1;
            nxt_state.bresp   = resp_for(waddr);
            if (sel_enable) begin
                nxt_state.enable = merge(state_ff.enable, wdata, wstrb);
            end
            if (sel_type) begin
                nxt_state.change_of_state_mode = merge(state_ff.change_of_state_mode, wdata, wstrb);
            end
            if (sel_pol) begin
                nxt_state.polarity = merge(state_ff.polarity, wdata, wstrb);
            end
            if (sel_status) begin
                clr = wstrb[0] ? wdata[CH_LSB +: NUM_CH] : '0;
            end
            if (sel_mask) begin
                nxt_state.mask = merge(state_ff.mask, wdata, wstrb);
            end
        end
        if (state_ff.bvalid && i_axil.bready) begin
            nxt_state.bvalid = 1'b0;
        end

        // Set wins over a clear in the same cycle
        nxt_state.status = (state_ff.status & ~clr) | event_hit;

        // AXI read: one cycle after the address is taken
        do_read = i_axil.arvalid && !state_ff.rvalid;
        if (do_read) begin
            nxt_state.rvalid = 1'b1;
            nxt_state.rresp  = resp_for(raddr);
            nxt_state.rdata  = '0;
            nxt_state.rdata[CH_LSB +: NUM_CH] = rd_bits;
        end else if (state_ff.rvalid && i_axil.rready) begin
            nxt_state.rvalid = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_ff                      <= '0;
            state_ff.enable               <= RST_ENABLE;
            state_ff.change_of_state_mode <= RST_TYPE;
            state_ff.polarity             <= RST_POL;
            state_ff.status               <= RST_STATUS;
            state_ff.mask                 <= RST_MASK;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_comb begin
        o_axil         = '0;
        o_axil.awready = !state_ff.aw_held;
        o_axil.wready  = !state_ff.w_held;
        o_axil.bvalid  = state_ff.bvalid;
        o_axil.bresp   = state_ff.bresp;
        o_axil.arready = !state_ff.rvalid;
        o_axil.rvalid  = state_ff.rvalid;
        o_axil.rdata   = state_ff.rdata;
        o_axil.rresp   = state_ff.rresp;
    end

    // ------------------------------------------------------------
    // Interrupt output
    // ------------------------------------------------------------
    // Gates of registered bits only, so no bus activity can glitch it
    assign o_irq = |(state_ff.status & state_ff.mask);

endmodule : cos_irq_ctrl

/* File: cos_irq_ctrl_assertions.sv */
// Checker for the interrupt block, watching only its top ports.
// Assumes the single clock domain and synchronous reset of the design.
`timescale 1ns/1ps
module cos_irq_ctrl_assertions
    import cos_irq_pkg::*;
(
    input wire logic              i_clk,
    input wire logic              i_rst,
    input wire axil_req_t         i_axil,
    input wire axil_rsp_t         o_axil,
    input wire logic [NUM_CH-1:0] i_chan,
    input wire logic              o_irq
);
    // ----------------------------------------
    // Helper state
    // ----------------------------------------
    logic              wrote_ff;
    logic [ADDR_W-1:0] rd_addr_ff;
    logic              rd_cfg;
    logic              rd_mapped;
    always_ff @(posedge i_clk) begin
        wrote_ff <= i_rst ? 1'b0 : (wrote_ff | (i_axil.awvalid & o_axil.awready));
        if (i_axil.arvalid && o_axil.arready) begin
            rd_addr_ff <= i_axil.araddr;
        end
    end
    // Lane bits [1:0] are ignored by the decoder
    assign rd_cfg    = rd_addr_ff[15:2] == 14'h2006 || rd_addr_ff[15:2] == 14'h2007;
    assign rd_mapped = rd_addr_ff[15:2] >= 14'h2005 && rd_addr_ff[15:2] <= 14'h200a;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence aw_w_taken;
        i_axil.awvalid && o_axil.awready && i_axil.wvalid && o_axil.wready;
    endsequence
    sequence ar_taken;
        i_axil.arvalid && o_axil.arready;
    endsequence

    wr_answer_a: assert property (aw_w_taken |-> ##2 o_axil.bvalid)
        else $error("write response late");
    rd_answer_a: assert property (ar_taken |=> o_axil.rvalid)
        else $error("read response late");
    b_hold_a: assert property (o_axil.bvalid && !i_axil.bready |=> o_axil.bvalid && $stable(o_axil.bresp))
        else $error("write response dropped");
    r_hold_a: assert property (o_axil.rvalid && !i_axil.rready |=> o_axil.rvalid && $stable(o_axil.rdata))
        else $error("read data dropped");
    ar_refuse_a: assert property (o_axil.rvalid |-> !o_axil.arready)
        else $error("address taken during read answer");
    upper_zero_a: assert property (o_axil.rvalid && rd_cfg |-> o_axil.rdata[31:8] == 24'h0)
        else $error("config upper bits not zero");
    unmapped_rd_a: assert property (o_axil.rvalid && !rd_mapped |-> o_axil.rresp == RESP_SLVERR && o_axil.rdata == 32'h0)
        else $error("unmapped read answered wrongly");
    quiet_reset_a: assert property ($fell(i_rst) |-> !o_irq)
        else $error("interrupt high after reset");
    no_enable_a: assert property (!wrote_ff |-> !o_irq)
        else $error("interrupt without any enable");
endmodule : cos_irq_ctrl_assertions

bind cos_irq_ctrl cos_irq_ctrl_assertions cos_irq_ctrl_assertions_i (.i_clk(i_clk), .i_rst(i_rst),
    .i_axil(i_axil), .o_axil(o_axil), .i_chan(i_chan), .o_irq(o_irq));

/* File: cos_irq_host.sv */
// Host model: AXI4-Lite master issuing one transfer at a time.
// Assumes the slave's outputs change only by non-blocking updates.
`timescale 1ns/1ps
module cos_irq_host
    import cos_irq_pkg::*;
(
    input  wire logic      i_clk,
    output axil_req_t      o_req,
    input  wire axil_rsp_t i_rsp
);
    initial o_req = '0;
    // Released payload is inverted so stale values are never trusted
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        bit aw_ok = 1'b0;
        bit w_ok  = 1'b0;
        bit b_ok  = 1'b0;
        @(posedge i_clk);
        o_req.awaddr  <= a;
        o_req.awvalid <= 1'b1;
        o_req.wdata   <= d;
        o_req.wstrb   <= s;
        o_req.wvalid  <= 1'b1;
        o_req.bready  <= 1'b1;
        while (!b_ok) begin
            @(posedge i_clk);
            if (aw_ok && w_ok && i_rsp.bvalid) begin
                b_ok = 1'b1;
                r = i_rsp.bresp;
                o_req.bready <= 1'b0;
            end
            if (!aw_ok && i_rsp.awready) begin
                aw_ok = 1'b1;
                o_req.awvalid <= 1'b0;
                o_req.awaddr  <= ~a;
            end
            if (!w_ok && i_rsp.wready) begin
                w_ok = 1'b1;
                o_req.wvalid <= 1'b0;
                o_req.wdata  <= ~d;
            end
        end
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic [1:0] r);
        bit ar_ok = 1'b0;
        bit r_ok  = 1'b0;
        @(posedge i_clk);
        o_req.araddr  <= a;
        o_req.arvalid <= 1'b1;
        o_req.rready  <= 1'b1;
        while (!r_ok) begin
            @(posedge i_clk);
            if (ar_ok && i_rsp.rvalid) begin
                r_ok = 1'b1;
                d = i_rsp.rdata;
                r = i_rsp.rresp;
                o_req.rready <= 1'b0;
            end
            if (!ar_ok && i_rsp.arready) begin
                ar_ok = 1'b1;
                o_req.arvalid <= 1'b0;
                o_req.araddr  <= ~a;
            end
        end
    endtask : rd
endmodule : cos_irq_host

/* File: channel_cos_level_interrupt_tb.sv */
// Self-checking bench: register access, then random channel trials.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module channel_cos_level_interrupt_tb;
    import cos_irq_pkg::*;
    logic              i_clk  = 1'b0;
    logic              i_rst  = 1'b1;
    logic [NUM_CH-1:0] i_chan = '0;
    axil_req_t         req;
    axil_rsp_t         rsp;
    logic              o_irq;
    int                n_mismatch = 0;
    int                n_tests    = 0;
    int                cycles     = 0;
    logic [31:0]       rd_d;
    logic [1:0]        rd_r;
    logic [7:0]        en, ty, po, c0, c1, mk, st;

    always #25 i_clk = ~i_clk;
    cos_irq_host cos_irq_host_i (.i_clk(i_clk), .o_req(req), .i_rsp(rsp));
    cos_irq_ctrl cos_irq_ctrl_i (.i_clk(i_clk), .i_rst(i_rst), .i_axil(req), .o_axil(rsp),
                                 .i_chan(i_chan), .o_irq(o_irq));

    task automatic report_and_stop();
        if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : report_and_stop
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
        cos_irq_host_i.wr(a, d, s, rd_r);
        check("bresp", {30'h0, rd_r}, {30'h0, (a == 16'h8000) ? RESP_SLVERR : RESP_OKAY});
    endtask : wr
    task automatic rchk(input logic [15:0] a, input logic [31:0] e, input string w);
        cos_irq_host_i.rd(a, rd_d, rd_r);
        check({w, " resp"}, {30'h0, rd_r}, {30'h0, (a == 16'h8000) ? RESP_SLVERR : RESP_OKAY});
        check(w, rd_d, e);
    endtask : rchk
    // Level bits stay latched from both input phases
    function automatic logic [7:0] exp_status(input logic [7:0] e, t, p, a, b);
        return e & ((t & (a ^ b)) | (~t & ((p & (a | b)) | (~p & ~(a & b)))));
    endfunction : exp_status

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    initial begin
        void'($urandom(27));
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        rchk(OFS_INT_ENABLE, 32'h0, "enable");
        rchk(OFS_TRIGGER_TYPE, 32'h0, "type");
        rchk(OFS_LEVEL_POL, 32'h0, "polarity");
        rchk(OFS_INT_MASK, 32'hff, "mask");
        wr(OFS_TRIGGER_TYPE, 32'hffff_ffa5, 4'h1);
        rchk(OFS_TRIGGER_TYPE, 32'ha5, "type byte");
        wr(OFS_LEVEL_POL, 32'h0000_ff5a, 4'h3);
        rchk(OFS_LEVEL_POL, 32'h5a, "polarity half");
        wr(OFS_LEVEL_POL, 32'h0000_00ff, 4'he);
        rchk(OFS_LEVEL_POL, 32'h5a, "polarity lane");
        rchk(16'h8000, 32'h0, "unmapped");
        wr(16'h8000, 32'hff, 4'hf);
        rchk(OFS_INT_ENABLE, 32'h0, "enable kept");
        for (int k = 0; k < 40; k++) begin
            {en, ty, po, c0, c1, mk} = {$urandom, $urandom};
            if (k < 8) en = 8'h01 << k;
            @(posedge i_clk);
            i_chan <= c0;
            repeat (6) @(posedge i_clk);
            wr(OFS_INT_ENABLE, {24'h0, en}, 4'h1);
            wr(OFS_TRIGGER_TYPE, {24'h0, ty}, 4'hf);
            wr(OFS_LEVEL_POL, {24'h0, po}, 4'h3);
            wr(OFS_INT_MASK, {24'h0, mk}, 4'hf);
            repeat (6) @(posedge i_clk);
            wr(OFS_INT_STATUS, 32'hff, 4'h1);
            @(posedge i_clk);
            i_chan <= c1;
            repeat (8) @(posedge i_clk);
            st = exp_status(en, ty, po, c0, c1);
            rchk(OFS_INPUT_DATA, {24'h0, c1}, "input");
            rchk(OFS_INT_STATUS, {24'h0, st}, "status");
            @(negedge i_clk);
            check("irq", {31'h0, o_irq}, {31'h0, |(st & mk)});
            wr(OFS_INT_ENABLE, 32'h0, 4'h1);
            wr(OFS_INT_STATUS, 32'hff, 4'h1);
            rchk(OFS_INT_STATUS, 32'h0, "cleared");
            @(negedge i_clk);
            check("irq off", {31'h0, o_irq}, 32'h0);
        end
        report_and_stop();
    end
endmodule : channel_cos_level_interrupt_tb
